// *** hdl/rocc_top.sv ***
`timescale 1ns/1ps
// Overview of operation
// R1 - Relative press captures next completed reading with its function and range.
// R2 - Relative indicator lights right after the press, before capture.
// R3 - With an active reference, readings show measured minus reference.
// R4 - Second press, power-off, or capture in another function cancels reference.
// R5 - Range change rescales stored reference by powers of ten before subtracting.
// R6 - Function change clears indicator; reference stays tagged with its function. Code keeps the indicator lit while a press is still armed (pend_q).
// R7 - Returning to original function restores reference and indicator unless replaced.
// R8 - Relative works in all functions; continuity uses the resistance reading.
// R9 - Raw converter result above full scale flags overrange regardless of reference.
// R10 - Corrected difference below negative full scale also flags overrange.
// R11 - Measurements and captures happen once per interval of about 0.4 s.
// R12 - Operator avoids mixing autoranging kilohm references with other modes.
// R13 - No restriction across fixed resistance ranges or autoranging megohms.
// R14 - Continuity button acts only while resistance function is selected.
// R15 - Continuity presses step visible, visible plus audible, then off.
// R16 - Detected continuity lights the top bar and, if audible, sounds tone.
// R17 - Fixed ranges declare continuity below half the range full scale.
// R18 - Auto kilohm threshold below 100 ohm; auto megohm below 100 Mohm.
// R19 - Continuity events as short as 50 us are caught.
// R20 - Any continuity event holds the indication at least 200 ms.
// R21 - Resistance readings continue and display while continuity is enabled.
// R22 - Tone is a square wave driven onto the external transducer.
// R23 - Each converter cycle lasts 400 ms, pacing readings and references.
// R24 - Reference and difference are signed counts.
// R25 - Visible-only continuity keeps the tone inactive.
module rocc_top
    import rocc_pkg::*;
#(
    parameter int MEAS_PERIOD = rocc_pkg::MEAS_CYC,
    parameter int HOLD_PERIOD = rocc_pkg::HOLD_CYC,
    parameter int TONE_HALF   = rocc_pkg::TONE_HALF_CYC
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // Operator buttons and fast continuity comparator (pins)
    input  wire logic                          ofs_btn,
    input  wire logic                          cont_btn,
    input  wire logic                          cont_cmp,
    // Function and range selection
    input  wire logic [rocc_pkg::FUNC_W-1:0]   func_sel,
    input  wire logic [rocc_pkg::RANGE_W-1:0]  range_sel,
    // Reading stream from the acquisition chip
    input  wire logic                          meas_valid,
    input  wire rocc_pkg::rocc_meas_t          meas,
    output logic                               conv_start_q,
    // Display values and indicators
    output logic signed [rocc_pkg::DISP_W-1:0] disp_value_q,
    output logic                               disp_valid_q,
    output logic                               overrange_flag_q,
    output logic                               ofs_ind_q,
    output logic                               cont_vis_ind_q,
    output logic                               cont_aud_ind_q,
    output logic                               cont_bar_q,
    // Transducer drive
    output logic                               tone_q
);
    import rocc_pkg::*;

    localparam int MW = $clog2(MEAS_PERIOD + 1);
    localparam int TW = $clog2(TONE_HALF + 1);
    localparam logic [MW-1:0] MEAS_LAST = MW'(MEAS_PERIOD - 1);
    localparam logic [TW-1:0] TONE_LAST = TW'(TONE_HALF - 1);

    // Decade of the active range, autorange steps added in
    function automatic logic [DEC_W-1:0] rocc_decade(input logic [FUNC_W-1:0] f,
                                                     input logic [RANGE_W-1:0] r,
                                                     input logic [1:0] s);
        logic [DEC_W-1:0] d;
        d = {1'b0, r};
        if (f == FUNC_OHMS && r == RANGE_AUTO_M) d = DEC_AUTO_M + {2'h0, s};
        if (f == FUNC_OHMS && r == RANGE_AUTO_K) d = DEC_AUTO_K + {2'h0, s};
        return d;
    endfunction : rocc_decade

    // Reference moved from its capture decade to the present one
    function automatic logic signed [31:0] rocc_scale(input logic signed [CNT_W-1:0] v,
                                                      input logic [DEC_W-1:0] from_d,
                                                      input logic [DEC_W-1:0] to_d);
        logic signed [31:0] acc;
        int                 up;
        int                 dn;
        acc = 32'(v);
        up  = int'(from_d) - int'(to_d);
        dn  = int'(to_d) - int'(from_d);
        for (int i = 0; i < 4; i++) begin
            if (i < up) acc = acc * 10;
            else if (i < dn) acc = acc / 10;
        end
        return acc;
    endfunction : rocc_scale

    // Continuity threshold by range
    function automatic logic rocc_below(input logic [RANGE_W-1:0] r,
                                        input logic [1:0] s,
                                        input logic signed [CNT_W-1:0] c);
        logic b;
        b = 1'b0;
        case (r)
            RANGE_AUTO_K: b = (s == 2'h0) && (int'(c) < AUTO_K_THR);
            RANGE_AUTO_M: b = (s != 2'h2) || (int'(c) < AUTO_M_THR);
            default:      b = (int'(c) < HALF_SCALE);
        endcase
        return b;
    endfunction : rocc_below

    logic [2:0]              s1_q;
    logic [2:0]              s2_q;
    logic [2:0]              s3_q;
    logic [2:0]              acc_q;
    logic [2:0]              prev_q;
    logic                    ofs_press;
    logic                    cont_press;
    logic                    is_ohms;
    logic                    pend_q;
    logic                    ref_valid_q;
    logic signed [CNT_W-1:0] ref_val_q;
    logic [FUNC_W-1:0]       ref_func_q;
    logic [DEC_W-1:0]        ref_dec_q;
    logic [DEC_W-1:0]        cur_dec;
    logic                    applied;
    logic signed [31:0]      diff;
    logic [MW-1:0]           meas_cnt_q;
    rocc_cont_t              cont_q;
    logic                    cont_event;
    logic                    held;
    logic [TW-1:0]           tone_cnt_q;

    // Pin synchroniser, a level is accepted when stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_q   <= PIN_RST;
            s2_q   <= PIN_RST;
            s3_q   <= PIN_RST;
            acc_q  <= PIN_RST;
            prev_q <= PIN_RST;
        end else begin
            s1_q   <= {cont_cmp, cont_btn, ofs_btn};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            acc_q  <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & acc_q);
            prev_q <= acc_q;
        end
    end

    assign ofs_press  = acc_q[0] & ~prev_q[0];
    assign cont_press = acc_q[1] & ~prev_q[1];
    assign is_ohms    = (func_sel == FUNC_OHMS);

    // Measurement pacing, one converter start per interval
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meas_cnt_q   <= '0;
            conv_start_q <= 1'b0;
        end else if (meas_cnt_q == MEAS_LAST) begin
            meas_cnt_q   <= '0;
            conv_start_q <= 1'b1;                     // [R11] [R23]
        end else begin
            meas_cnt_q   <= meas_cnt_q + 1'b1;
            conv_start_q <= 1'b0;
        end
    end

    // Reference arm, capture and cancel
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend_q      <= 1'b0;                      // [R4]
            ref_valid_q <= 1'b0;
            ref_val_q   <= REF_RST;
            ref_func_q  <= '0;
            ref_dec_q   <= '0;
        end else if (ofs_press) begin
            if (ofs_ind_q) begin
                pend_q      <= 1'b0;                  // [R4]
                ref_valid_q <= 1'b0;
            end else begin
                pend_q      <= 1'b1;                  // [R1]
            end
        end else if (meas_valid && pend_q) begin
            pend_q      <= 1'b0;
            ref_valid_q <= 1'b1;                      // [R1] [R4] [R8] [R13]
            ref_val_q   <= meas.count;                // [R24]
            ref_func_q  <= func_sel;
            ref_dec_q   <= rocc_decade(func_sel, range_sel, meas.sub);
        end
    end

    // Indicator follows arming or a reference tagged with this function
    always_ff @(posedge sys_clk) begin
        if (rst) ofs_ind_q <= 1'b0;
        else ofs_ind_q <= pend_q | (ref_valid_q & (func_sel == ref_func_q)); // [R2] [R6] [R7]
    end

    assign cur_dec = rocc_decade(func_sel, range_sel, meas.sub);
    assign applied = (ref_valid_q | pend_q) & (pend_q | (func_sel == ref_func_q));
    // While arming, the capture reading subtracts itself and shows zero
    assign diff    = 32'(meas.count) - (pend_q ? 32'(meas.count)
                                               : rocc_scale(ref_val_q, ref_dec_q, cur_dec)); // [R3] [R5] [R24]

    // Display value and overrange
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            disp_value_q     <= DISP_RST;
            disp_valid_q     <= 1'b0;
            overrange_flag_q <= 1'b0;
        end else begin
            disp_valid_q <= meas_valid;               // [R21]
            if (meas_valid) begin
                disp_value_q     <= applied ? diff[DISP_W-1:0] : DISP_W'(meas.count); // [R3]
                overrange_flag_q <= meas.over                                // [R9]
                                    | (applied & (diff < -FULL_SCALE))       // [R10]
                                    | (applied & (diff > FULL_SCALE));
            end
        end
    end

    // Continuity selection steps only in the resistance function
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cont_q <= CONT_OFF;
        end else if (!is_ohms) begin
            cont_q <= CONT_OFF;
        end else if (cont_press) begin                // [R14]
            case (cont_q)
                CONT_OFF: cont_q <= CONT_VIS;         // [R15]
                CONT_VIS: cont_q <= CONT_AUD;
                CONT_AUD: cont_q <= CONT_OFF;
                default:  cont_q <= CONT_OFF;
            endcase
        end
    end

    // Comparator pulse or an in-threshold reading both count as contact
    assign cont_event = (cont_q != CONT_OFF)
                        & (acc_q[2]                                               // [R19]
                           | (meas_valid & ~meas.over & rocc_below(range_sel, meas.sub, meas.count))); // [R17] [R18]

    rocc_stretch #(
        .HOLD    (HOLD_PERIOD)
    ) u_stretch (
        .sys_clk (sys_clk),
        .rst     (rst),
        .trig    (cont_event),                        // [R20]
        .active_q(held)
    );

    // Indicators and bar
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cont_vis_ind_q <= 1'b0;
            cont_aud_ind_q <= 1'b0;
            cont_bar_q     <= 1'b0;
        end else begin
            cont_vis_ind_q <= (cont_q != CONT_OFF);   // [R15]
            cont_aud_ind_q <= (cont_q == CONT_AUD);
            cont_bar_q     <= held & (cont_q != CONT_OFF); // [R16]
        end
    end

    // Square wave to the transducer while audible contact is held
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tone_cnt_q <= '0;
            tone_q     <= 1'b0;
        end else if (!(held && cont_q == CONT_AUD)) begin
            tone_cnt_q <= '0;
            tone_q     <= 1'b0;                       // [R25]
        end else if (tone_cnt_q == TONE_LAST) begin
            tone_cnt_q <= '0;
            tone_q     <= ~tone_q;                    // [R16] [R22]
        end else begin
            tone_cnt_q <= tone_cnt_q + 1'b1;
        end
    end

    sequence arm_s;
        ofs_press && !ofs_ind_q;
    endsequence

    sequence lit_s;
        ##1 pend_q ##1 ofs_ind_q;
    endsequence

    ofs_ind_on_a: assert property (@(posedge sys_clk) disable iff (rst)
        arm_s |-> lit_s)                              // [R2]
        else $error("relative indicator late after press");

    ref_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
        (meas_valid && pend_q && !ofs_press) |=> ref_valid_q && (ref_val_q == $past(meas.count)) && !pend_q) // [R1]
        else $error("reference not captured from reading");

    ofs_cancel_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ofs_press && ofs_ind_q) |=> !ref_valid_q && !pend_q ##1 !ofs_ind_q) // [R4]
        else $error("second press did not cancel reference");

    ofs_hidden_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ref_valid_q && !pend_q && func_sel != ref_func_q && $stable(func_sel)) |=> !ofs_ind_q) // [R6]
        else $error("indicator shown in other function");

    raw_over_a: assert property (@(posedge sys_clk) disable iff (rst)
        (meas_valid && meas.over) |=> overrange_flag_q) // [R9]
        else $error("raw overrange not flagged");

    neg_over_a: assert property (@(posedge sys_clk) disable iff (rst)
        (meas_valid && applied && diff < -FULL_SCALE) |=> overrange_flag_q) // [R10]
        else $error("negative difference overrange not flagged");

    ofs_subtract_a: assert property (@(posedge sys_clk) disable iff (rst)
        (meas_valid && ref_valid_q && !pend_q && func_sel == ref_func_q && ref_dec_q == cur_dec)
        |=> disp_value_q == DISP_W'($past(meas.count) - $past(ref_val_q))) // [R3]
        else $error("display is not reading minus reference");

    cont_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
        (!is_ohms) |=> (cont_q == CONT_OFF))          // [R14]
        else $error("continuity selected outside resistance");

    cont_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cont_press && is_ohms && cont_q == CONT_OFF) |=> (cont_q == CONT_VIS) ##1 cont_vis_ind_q) // [R15]
        else $error("continuity step from off wrong");

    tone_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
        (cont_q != CONT_AUD) |=> !tone_q)             // [R25]
        else $error("tone active without audible setting");

    meas_gap_a: assert property (@(posedge sys_clk) disable iff (rst)
        conv_start_q |=> !conv_start_q [*8])          // [R11]
        else $error("converter starts too close together");

endmodule : rocc_top

// *** hdl/rocc_pkg.sv ***
package rocc_pkg;

    // Clock rate and derived cycle counts
    localparam int CLK_KHZ        = 100_000;
    localparam int MEAS_TIME_MS   = 400;
    localparam int MEAS_CYC       = MEAS_TIME_MS * CLK_KHZ;
    localparam int HOLD_TIME_MS   = 200;
    localparam int HOLD_CYC       = HOLD_TIME_MS * CLK_KHZ;
    localparam int DETECT_TIME_US = 50;
    localparam int DETECT_CYC     = (DETECT_TIME_US * CLK_KHZ) / 1000;
    localparam int TONE_HZ        = 2000;
    localparam int TONE_HALF_CYC  = (CLK_KHZ * 1000) / (2 * TONE_HZ);

    // Converter and display limits, in counts
    localparam int FULL_SCALE     = 19999;
    localparam int HALF_SCALE     = 10000;
    localparam int AUTO_K_THR     = 1000;
    localparam int AUTO_M_THR     = 1000;

    // Widths
    localparam int CNT_W          = 17;
    localparam int DISP_W         = 18;
    localparam int FUNC_W         = 3;
    localparam int RANGE_W        = 3;
    localparam int DEC_W          = 4;

    // Function and resistance range codes
    localparam logic [FUNC_W-1:0]  FUNC_OHMS    = 3'h4;
    localparam logic [RANGE_W-1:0] RANGE_AUTO_M = 3'h4;
    localparam logic [RANGE_W-1:0] RANGE_AUTO_K = 3'h5;
    localparam logic [DEC_W-1:0]   DEC_AUTO_M   = 4'h4;
    localparam logic [DEC_W-1:0]   DEC_AUTO_K   = 4'h1;

    // Reset values
    localparam logic [2:0]         PIN_RST      = 3'h0;
    localparam logic [CNT_W-1:0]   REF_RST      = 17'h00000;
    localparam logic [DISP_W-1:0]  DISP_RST     = 18'h00000;

    // One completed reading from the converter
    typedef struct packed {
        logic signed [CNT_W-1:0] count;
        logic                    over;
        logic [1:0]              sub;
    } rocc_meas_t;

    // Continuity selection
    typedef enum logic [1:0] {
        CONT_OFF,
        CONT_VIS,
        CONT_AUD
    } rocc_cont_t;

endpackage : rocc_pkg

// *** hdl/rocc_stretch.sv ***
`timescale 1ns/1ps
module rocc_stretch #(
    parameter int HOLD = 20_000_000
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Event in, held indication out
    input  wire logic trig,
    output logic      active_q
);
    import rocc_pkg::*;

    localparam int CW = $clog2(HOLD + 1);
    localparam logic [CW-1:0] LOAD = CW'(HOLD - 1);
    localparam logic [CW-1:0] ZERO = '0;

    logic [CW-1:0] left_q;

    // Reload on every event, count the hold down afterwards
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            left_q   <= ZERO;
            active_q <= 1'b0;
        end else if (trig) begin
            left_q   <= LOAD;                        // [R20]
            active_q <= 1'b1;
        end else if (left_q != ZERO) begin
            left_q   <= left_q - 1'b1;
        end else begin
            active_q <= 1'b0;
        end
    end

    hold_min_a: assert property (@(posedge sys_clk) disable iff (rst)
        trig |=> active_q [*8])                      // [R20]
        else $error("indication not held after event");

endmodule : rocc_stretch

// *** verif/rocc_adc_model.sv ***
`timescale 1ns/1ps
// Converter stand-in: answers a start with one reading, only while the bench asks for one
module rocc_adc_model (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // Start from the block and the bench's reading request
    input  wire logic                 conv_start_q,
    input  wire logic                 go,
    input  wire logic [3:0]           lat,
    input  wire rocc_pkg::rocc_meas_t next_meas,
    // Reading stream back to the block
    output logic                      meas_valid,
    output rocc_pkg::rocc_meas_t      meas
);
    import rocc_pkg::*;
    logic [3:0] lat_q;
    // Conversion delay, prompt or slow as the bench sets it
    always_ff @(posedge sys_clk) begin
        meas_valid <= 1'b0;
        if (rst) begin
            lat_q <= 4'h0;
        end else if (conv_start_q && go) begin
            lat_q <= lat;
        end else if (lat_q != 4'h0) begin
            lat_q <= lat_q - 4'h1;
            meas_valid <= (lat_q == 4'h1);
        end
    end
    // Reading bus shows a changing pattern outside its valid cycle
    always_ff @(posedge sys_clk) begin
        if (rst) meas <= '0;
        else meas <= (lat_q == 4'h1) ? next_meas : ~meas;
    end
endmodule : rocc_adc_model

// *** verif/test_relative_offset_continuity_ctl.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("Error t=%0t got %0h want %0h", $time, a, b); end end
module test_relative_offset_continuity_ctl;
    import rocc_pkg::*;
    localparam int MP = 200;
    localparam int HP = 50;
    logic               sys_clk = 1'b0, rst = 1'b1, go = 1'b0;
    logic               ofs_btn = 1'b0, cont_btn = 1'b0, cont_cmp = 1'b0;
    logic [2:0]         func_sel = 3'h0, range_sel = 3'h2;
    logic [3:0]         lat = 4'h1;
    rocc_meas_t         nm = '0, meas;
    logic               meas_valid, conv_start_q, disp_valid_q, overrange_flag_q, ofs_ind_q;
    logic               cont_vis_ind_q, cont_aud_ind_q, cont_bar_q, tone_q;
    logic signed [17:0] disp_value_q;
    logic signed [16:0] rc;
    logic [19:0]        e;
    logic [19:0]        exp_q [$];
    int                 err_total = 0, tests_run = 0, gap = 0, rs;
    bit                 seen = 1'b0;
    logic [2:0]         t_rng [7] = '{3'h0, 3'h0, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4};
    logic [1:0]         t_sub [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
    logic signed [16:0] t_cnt [7] = '{17'sh270f, 17'sh2710, 17'sh3e7, 17'sh3e8, 17'sh1f4, 17'sh3e7, 17'sh3e8};
    logic               t_bar [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

    rocc_top #(.MEAS_PERIOD(MP), .HOLD_PERIOD(HP), .TONE_HALF(4)) dut (
        .sys_clk(sys_clk), .rst(rst), .ofs_btn(ofs_btn), .cont_btn(cont_btn), .cont_cmp(cont_cmp),
        .func_sel(func_sel), .range_sel(range_sel), .meas_valid(meas_valid), .meas(meas),
        .conv_start_q(conv_start_q), .disp_value_q(disp_value_q), .disp_valid_q(disp_valid_q),
        .overrange_flag_q(overrange_flag_q), .ofs_ind_q(ofs_ind_q), .cont_vis_ind_q(cont_vis_ind_q),
        .cont_aud_ind_q(cont_aud_ind_q), .cont_bar_q(cont_bar_q), .tone_q(tone_q));

    rocc_adc_model adc (.sys_clk(sys_clk), .rst(rst), .conv_start_q(conv_start_q), .go(go), .lat(lat),
        .next_meas(nm), .meas_valid(meas_valid), .meas(meas));

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    // Start pulses one measurement period apart
    always @(posedge sys_clk) if (!rst) begin
        gap++;
        if (conv_start_q === 1'b1) begin
            if (seen) `CHK(gap, MP)
            gap = 0;
            seen = 1'b1;
        end
    end

    // Each displayed reading against the oldest note
    always @(posedge sys_clk) if (disp_valid_q === 1'b1) begin
        if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
        else begin
            e = exp_q.pop_front();
            `CHK(overrange_flag_q, e[18])
            if (e[19]) `CHK(disp_value_q, e[17:0])
        end
    end

    task automatic end_of_test;
        $display("Counts: %0d compares, %0d mismatches", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask : done

    task automatic press(input bit r);
        @(posedge sys_clk);
        if (r) ofs_btn <= 1'b1;
        else cont_btn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        ofs_btn <= 1'b0;
        cont_btn <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask : press

    // One reading: count, raw over, sub-step, expected value, expected flag, value checked
    task automatic reading(input logic signed [16:0] c, input logic o, input logic [1:0] s,
                           input logic signed [17:0] ev, input logic eo, input logic ck);
        int n;
        @(posedge sys_clk);
        nm <= '{count: c, over: o, sub: s};
        lat <= c[0] ? 4'h9 : 4'h1;
        go <= 1'b1;
        exp_q.push_back({ck, eo, ev});
        n = 0;
        while (disp_valid_q !== 1'b1 && n < 3 * MP) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 3 * MP) begin
            err_total++;
            $display("Error t=%0t reading never shown", $time);
            end_of_test();
        end
        go <= 1'b0;
        @(posedge sys_clk);
    endtask : reading

    // Short comparator contact, then bar, tone and hold time
    task automatic pulse(input logic aud);
        int n;
        logic p;
        @(posedge sys_clk);
        cont_cmp <= 1'b1;
        repeat (5) @(posedge sys_clk);
        cont_cmp <= 1'b0;
        repeat (4) @(posedge sys_clk);
        `CHK(cont_bar_q, 1'b1)
        n = 0;
        p = tone_q;
        repeat (24) begin
            @(posedge sys_clk);
            if (tone_q !== p) n++;
            p = tone_q;
        end
        `CHK(n > 2, aud)
        repeat (15) @(posedge sys_clk);
        `CHK(cont_bar_q, 1'b1)
        repeat (20) @(posedge sys_clk);
        `CHK(cont_bar_q, 1'b0)
    endtask : pulse

    // Main sequence
    initial begin
        rs = $urandom(4558);
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        `CHK({ofs_ind_q, cont_vis_ind_q, cont_aud_ind_q, cont_bar_q, tone_q, overrange_flag_q}, 6'h00)
        repeat (3) begin
            rc = 17'($urandom_range(19999, 0));
            reading(rc, 1'b0, 2'h0, rc, 1'b0, 1'b1);
        end
        press(1'b0);
        `CHK(cont_vis_ind_q, 1'b0)
        done("reset and plain readings");
        press(1'b1);
        `CHK(ofs_ind_q, 1'b1)
        reading(17'sh3e8, 1'b0, 2'h0, 18'sh0, 1'b0, 1'b1);
        reading(17'sh4f6, 1'b0, 2'h0, 18'sh10e, 1'b0, 1'b1);
        reading(17'sh352, 1'b0, 2'h0, -18'sh96, 1'b0, 1'b1);
        range_sel <= 3'h3;
        reading(17'sh1f4, 1'b0, 2'h0, 18'sh190, 1'b0, 1'b1);
        range_sel <= 3'h1;
        reading(17'sh3a98, 1'b0, 2'h0, 18'sh1388, 1'b0, 1'b1);
        reading(-17'sh3a98, 1'b0, 2'h0, 18'sh0, 1'b1, 1'b0);
        reading(17'sh1388, 1'b1, 2'h0, 18'sh0, 1'b1, 1'b0);
        func_sel <= 3'h1;
        repeat (3) @(posedge sys_clk);
        `CHK(ofs_ind_q, 1'b0)
        reading(17'sh2bc, 1'b0, 2'h0, 18'sh2bc, 1'b0, 1'b1);
        func_sel <= 3'h0;
        range_sel <= 3'h2;
        repeat (3) @(posedge sys_clk);
        `CHK(ofs_ind_q, 1'b1)
        reading(17'sh5dc, 1'b0, 2'h0, 18'sh1f4, 1'b0, 1'b1);
        done("relative offset");
        func_sel <= FUNC_OHMS;
        range_sel <= 3'h0;
        press(1'b0);
        `CHK({cont_vis_ind_q, cont_aud_ind_q}, 2'b10)
        for (int i = 0; i < 7; i++) begin
            range_sel <= t_rng[i];
            reading(t_cnt[i], 1'b0, t_sub[i], t_cnt[i], 1'b0, 1'b1);
            repeat (2) @(posedge sys_clk);
            `CHK(cont_bar_q, t_bar[i])
            repeat (HP + 10) @(posedge sys_clk);
        end
        range_sel <= 3'h0;
        pulse(1'b0);
        press(1'b0);
        `CHK({cont_vis_ind_q, cont_aud_ind_q}, 2'b11)
        pulse(1'b1);
        done("continuity");
        // Ohms reference across fixed ranges 0 and 1, hidden in another function, restored on return, then cancelled
        press(1'b1);
        reading(17'sh12c, 1'b0, 2'h0, 18'sh0, 1'b0, 1'b1);
        reading(17'sh1f4, 1'b0, 2'h0, 18'shc8, 1'b0, 1'b1);
        range_sel <= 3'h1;
        reading(17'sh212, 1'b0, 2'h0, 18'sh1f4, 1'b0, 1'b1);
        press(1'b0);
        `CHK({cont_vis_ind_q, cont_aud_ind_q}, 2'b00)
        func_sel <= 3'h0;
        range_sel <= 3'h2;
        repeat (3) @(posedge sys_clk);
        `CHK(ofs_ind_q, 1'b0)
        reading(17'sh5dc, 1'b0, 2'h0, 18'sh5dc, 1'b0, 1'b1);
        func_sel <= FUNC_OHMS;
        range_sel <= 3'h1;
        repeat (3) @(posedge sys_clk);
        `CHK(ofs_ind_q, 1'b1)
        press(1'b1);
        `CHK(ofs_ind_q, 1'b0)
        reading(17'sh212, 1'b0, 2'h0, 18'sh212, 1'b0, 1'b1);
        done("relative in ohms");
        `CHK(exp_q.size(), 0)
        end_of_test();
    end
endmodule : test_relative_offset_continuity_ctl
